// ===== hw/ctr_regs.sv
// commutation tuning register bank with apb slave and setting timers
`timescale 1ns/10ps
`default_nettype none
`include "ctr_params.svh"
module ctr_regs #(
   parameter int ADDR_W = 12,
   parameter int TICK_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic pwm_edge,
   input wire logic comparator_pin,
   output logic blanking_active,
   output logic comparator_filtered,
   output logic high_inductance_filter_enable,
   output logic [6:0] align_duty_limit_pct,
   output logic [1:0] standby_exit_hysteresis,
   output logic [3:0] edge_blanking_time,
   output logic [2:0] comparator_deglitch_time,
   output logic [31:0] fault_settings_one,
   output logic [31:0] fault_settings_two
);
   import ctr_pkg::*;

   // -------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------
   localparam int MAX_BLANK_CYC = 15 * `CTR_CYC_PER_STEP;
   localparam int CYC_PER_STEP = `CTR_CYC_PER_STEP;

   // refuse sizes the decode and timers cannot serve
   if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be between 12 and 32");
   end
   if (MAX_BLANK_CYC >= (1 << TICK_W)) begin : g_bad_tick
      $error("TICK_W too narrow for the longest interval");
   end
   if (CYC_PER_STEP < 1) begin : g_bad_clk
      $error("clock too slow for one microsecond step");
   end

   // -------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_FAULT_ONE = ADDR_W'({`CTR_IDX_FAULT_ONE, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_FAULT_TWO = ADDR_W'({`CTR_IDX_FAULT_TWO, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_TUNING = ADDR_W'({`CTR_IDX_TUNING, 2'b00});

   wire logic hit_fault_one;
   wire logic hit_fault_two;
   wire logic hit_tuning;
   wire logic hit_any;
   wire logic setup_phase;
   wire logic access_done;
   wire logic do_write;
   logic pready_q;

   // address match per register word
   assign hit_fault_one = (paddr == ADDR_FAULT_ONE);
   assign hit_fault_two = (paddr == ADDR_FAULT_TWO);
   assign hit_tuning = (paddr == ADDR_TUNING);
   assign hit_any = hit_fault_one | hit_fault_two | hit_tuning;

   // transfer phases
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_q;
   assign do_write = access_done & pwrite & hit_any;

   // -------------------------------------------------------------
   // register words
   // -------------------------------------------------------------
   ctr_wr_if wr_bus ();
   ctr_word_t fault_one_w;
   ctr_word_t fault_two_w;
   ctr_word_t tuning_w;
   ctr_tuning_s tuning_f;

   // shared write data and byte lanes
   assign wr_bus.wdata = pwdata;
   assign wr_bus.strb = pstrb;

   // first fault settings word
   ctr_reg_word #(
      .RESET_VALUE(`CTR_RST_FAULT_ONE)
   ) u_fault_one (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(do_write & hit_fault_one),
      .wr(wr_bus.sink),
      .value(fault_one_w)
   );

   // second fault settings word
   ctr_reg_word #(
      .RESET_VALUE(`CTR_RST_FAULT_TWO)
   ) u_fault_two (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(do_write & hit_fault_two),
      .wr(wr_bus.sink),
      .value(fault_two_w)
   );

   // algorithm tuning word, all bits stored incl. reserved
   ctr_reg_word #(
      .RESET_VALUE(`CTR_RST_TUNING)
   ) u_tuning (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(do_write & hit_tuning),
      .wr(wr_bus.sink),
      .value(tuning_w)
   );

   assign tuning_f = ctr_tuning_s'(tuning_w);

   // -------------------------------------------------------------
   // bus answer
   // -------------------------------------------------------------
   logic pslverr_q;
   ctr_word_t prdata_q;
   ctr_word_t rd_mux;

   // read select, unmapped reads return zero
   assign rd_mux = hit_tuning ? tuning_w :
                   hit_fault_one ? fault_one_w :
                   hit_fault_two ? fault_two_w : 32'h0000_0000;

   // answer prepared in setup, shown through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup_phase;
         pslverr_q <= setup_phase & ~hit_any;
         if (setup_phase) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // -------------------------------------------------------------
   // setting decode
   // -------------------------------------------------------------
   localparam logic [55:0] ALIGN_TABLE = `CTR_ALIGN_PCT_TABLE;
   localparam logic [TICK_W-1:0] STEP_CYC = TICK_W'(CYC_PER_STEP);

   wire logic [6:0] align_pct;
   wire logic [TICK_W-1:0] blank_cyc;
   wire logic [TICK_W-1:0] degl_cyc;

   // align duty code picks a percent from the table
   assign align_pct = ALIGN_TABLE[tuning_f.align*7 +: 7];
   // microsecond codes scaled to clock cycles
   assign blank_cyc = TICK_W'(tuning_f.blank * STEP_CYC);
   assign degl_cyc = TICK_W'(tuning_f.deglitch * STEP_CYC);

   logic filt_q;
   logic [6:0] align_q;
   logic [1:0] hyst_q;
   logic [3:0] blank_code_q;
   logic [2:0] degl_code_q;
   ctr_word_t fault_one_q;
   ctr_word_t fault_two_q;

   // settings driven out from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_q <= 1'b0;
         align_q <= 7'h0A;
         hyst_q <= 2'h0;
         blank_code_q <= 4'h0;
         degl_code_q <= 3'h0;
         fault_one_q <= `CTR_RST_FAULT_ONE;
         fault_two_q <= `CTR_RST_FAULT_TWO;
      end else begin
         filt_q <= tuning_f.filter_en;
         align_q <= align_pct;
         hyst_q <= tuning_f.hyst;
         blank_code_q <= tuning_f.blank;
         degl_code_q <= tuning_f.deglitch;
         fault_one_q <= fault_one_w;
         fault_two_q <= fault_two_w;
      end
   end

   assign high_inductance_filter_enable = filt_q;
   assign align_duty_limit_pct = align_q;
   assign standby_exit_hysteresis = hyst_q;
   assign edge_blanking_time = blank_code_q;
   assign comparator_deglitch_time = degl_code_q;
   assign fault_settings_one = fault_one_q;
   assign fault_settings_two = fault_two_q;

   // -------------------------------------------------------------
   // blanking after pwm edges
   // -------------------------------------------------------------
   logic [TICK_W-1:0] blank_cnt_q;
   logic [TICK_W-1:0] blank_cnt_d;
   logic blank_q;

   // an edge restarts the window, zero code means no blanking
   assign blank_cnt_d = pwm_edge ? blank_cyc :
                        (blank_cnt_q != '0) ? blank_cnt_q - TICK_W'(1) : blank_cnt_q;

   // window counter and its flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_cnt_q <= '0;
         blank_q <= 1'b0;
      end else begin
         blank_cnt_q <= blank_cnt_d;
         blank_q <= (blank_cnt_d != '0);
      end
   end

   assign blanking_active = blank_q;

   // -------------------------------------------------------------
   // comparator deglitch
   // -------------------------------------------------------------
   logic cmp_meta_q;
   logic cmp_sync_q;
   logic cmp_out_q;
   logic [TICK_W-1:0] stable_cnt_q;
   wire logic cmp_differs;
   wire logic cmp_accept;

   // pin passes two flip-flops first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_meta_q <= 1'b0;
         cmp_sync_q <= 1'b0;
      end else begin
         cmp_meta_q <= comparator_pin;
         cmp_sync_q <= cmp_meta_q;
      end
   end

   // new level accepted once it has held for the deglitch time
   assign cmp_differs = (cmp_sync_q != cmp_out_q);
   assign cmp_accept = cmp_differs & (stable_cnt_q >= degl_cyc);

   // count how long the new level has held, ignored in blanking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_cnt_q <= '0;
         cmp_out_q <= 1'b0;
      end else if (!cmp_differs || blank_q) begin
         stable_cnt_q <= '0;
      end else if (cmp_accept) begin
         stable_cnt_q <= '0;
         cmp_out_q <= cmp_sync_q;
      end else begin
         stable_cnt_q <= stable_cnt_q + TICK_W'(1);
      end
   end

   assign comparator_filtered = cmp_out_q;
endmodule : ctr_regs
`default_nettype wire

// ===== hw/ctr_params.svh
// constants for the commutation tuning register bank
// What this block does
// - tuning register at index 9Ch, resets to 00200000h, bit 21 set
// - bits 30..27 set blanking after each PWM edge, n microseconds
// - bits 26..24 set comparator deglitch time, n microseconds
// - bit 22 one enables the high-inductance degauss filter
// - bits 20..18 cap align duty: 10,15,20,25,30,40,50,100 percent
// - bits 17..16 give standby exit hysteresis of 0 to 3 percent
// - fault settings registers at indexes 92h and 94h, reset zero
// - every read/write field reads back and resets to its default
`ifndef CTR_PARAMS_SVH
`define CTR_PARAMS_SVH

// -------------------------------------------------------------
// register indexes (byte address is four times the index)
// -------------------------------------------------------------
`define CTR_IDX_FAULT_ONE 12'h092
`define CTR_IDX_FAULT_TWO 12'h094
`define CTR_IDX_TUNING 12'h09C

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define CTR_RST_FAULT_ONE 32'h0000_0000
`define CTR_RST_FAULT_TWO 32'h0000_0000
`define CTR_RST_TUNING 32'h0020_0000

// -------------------------------------------------------------
// tuning field positions
// -------------------------------------------------------------
`define CTR_BLANK_MSB 30
`define CTR_BLANK_LSB 27
`define CTR_DEGL_MSB 26
`define CTR_DEGL_LSB 24
`define CTR_FILT_BIT 22
`define CTR_ALIGN_MSB 20
`define CTR_ALIGN_LSB 18
`define CTR_HYST_MSB 17
`define CTR_HYST_LSB 16

// -------------------------------------------------------------
// align duty limits in percent, codes 0..7
// -------------------------------------------------------------
`define CTR_ALIGN_PCT_TABLE {7'd100, 7'd50, 7'd40, 7'd30, 7'd25, 7'd20, 7'd15, 7'd10}

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define CTR_CLK_PERIOD_NS 100
`define CTR_STEP_TIME_NS 1000
`define CTR_CYC_PER_STEP (`CTR_STEP_TIME_NS / `CTR_CLK_PERIOD_NS)

`endif

// ===== hw/ctr_pkg.sv
// types of the commutation tuning register bank
package ctr_pkg;

   // field view of the tuning register
   typedef struct packed {
      logic parity;
      logic [3:0] blank;
      logic [2:0] deglitch;
      logic rsvd_23;
      logic filter_en;
      logic rsvd_21;
      logic [2:0] align;
      logic [1:0] hyst;
      logic [15:0] rsvd_low;
   } ctr_tuning_s;

   typedef logic [31:0] ctr_word_t;

endpackage : ctr_pkg

// ===== hw/ctr_wr_if.sv
// write carrier from the bus slave to the register words
`timescale 1ns/10ps
`default_nettype none
interface ctr_wr_if;
   import ctr_pkg::*;
   ctr_word_t wdata;
   logic [3:0] strb;

   modport source (output wdata, output strb);
   modport sink (input wdata, input strb);
endinterface : ctr_wr_if
`default_nettype wire

// ===== hw/ctr_reg_word.sv
// one 32-bit read/write register word with byte strobes
`timescale 1ns/10ps
`default_nettype none
module ctr_reg_word #(
   parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   ctr_wr_if.sink wr,
   output logic [31:0] value
);
   import ctr_pkg::*;

   ctr_word_t word_q;
   ctr_word_t word_d;

   // byte lanes merge the new data into the stored word
   always_comb begin
      word_d = word_q;
      for (int i = 0; i < 4; i++) begin
         if (wr_en && wr.strb[i]) begin
            word_d[i*8 +: 8] = wr.wdata[i*8 +: 8];
         end
      end
   end

   // storage, default value under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= RESET_VALUE;
      end else begin
         word_q <= word_d;
      end
   end

   assign value = word_q;
endmodule : ctr_reg_word
`default_nettype wire

// ===== sim/ctr_regs_assertions.sv
// port checks for the commutation tuning register bank
`timescale 1ns/10ps
`default_nettype none
module ctr_regs_checker #(
   parameter int ADDR_W = 12,
   parameter int TICK_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic pwm_edge,
   input wire logic blanking_active,
   input wire logic high_inductance_filter_enable,
   input wire logic [6:0] align_duty_limit_pct,
   input wire logic [1:0] standby_exit_hysteresis,
   input wire logic [3:0] edge_blanking_time,
   input wire logic [2:0] comparator_deglitch_time,
   input wire logic [31:0] fault_settings_one
);
   // -----------------------------
   // decode of completing transfers
   // -----------------------------
   wire logic mapped = paddr == 'h248 || paddr == 'h250 || paddr == 'h270;
   wire logic rd_done = psel && penable && pready && !pwrite;
   wire logic rd_tun = rd_done && paddr == 'h270;
   wire logic rd_f1 = rd_done && paddr == 'h248;

   // align code to percent
   function automatic logic [6:0] pct(input logic [2:0] c);
      case (c)
         3'd0: pct = 7'd10;
         3'd1: pct = 7'd15;
         3'd2: pct = 7'd20;
         3'd3: pct = 7'd25;
         3'd4: pct = 7'd30;
         3'd5: pct = 7'd40;
         3'd6: pct = 7'd50;
         default: pct = 7'd100;
      endcase
   endfunction : pct

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_next_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   blank_code_a: assert property (rd_tun |-> edge_blanking_time == prdata[30:27]) else $error("blank code");
   degl_code_a: assert property (rd_tun |-> comparator_deglitch_time == prdata[26:24]) else $error("deglitch");
   filter_en_a: assert property (rd_tun |-> high_inductance_filter_enable == prdata[22]) else $error("filter");
   align_pct_a: assert property (rd_tun |-> align_duty_limit_pct == pct(prdata[20:18])) else $error("align");
   hyst_code_a: assert property (rd_tun |-> standby_exit_hysteresis == prdata[17:16]) else $error("hyst");
   fault_copy_a: assert property (rd_f1 |-> fault_settings_one == prdata) else $error("fault copy");
   blank_run_a: assert property (pwm_edge && edge_blanking_time == 4'h1 |=> blanking_active [*8])
      else $error("blanking too short");
   blank_off_a: assert property (pwm_edge && edge_blanking_time == 4'h0 && !blanking_active |=> !blanking_active)
      else $error("blanking at code zero");

   cover property (rd_tun);
   cover property (pslverr && pready);
   cover property (pwm_edge && edge_blanking_time == 4'h1);
endmodule : ctr_regs_checker

bind ctr_regs ctr_regs_checker #(.ADDR_W(ADDR_W), .TICK_W(TICK_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .pwm_edge(pwm_edge), .blanking_active(blanking_active),
   .high_inductance_filter_enable(high_inductance_filter_enable), .align_duty_limit_pct(align_duty_limit_pct),
   .standby_exit_hysteresis(standby_exit_hysteresis), .edge_blanking_time(edge_blanking_time),
   .comparator_deglitch_time(comparator_deglitch_time), .fault_settings_one(fault_settings_one));
`default_nettype wire

// ===== sim/test_commutation_tuning_regs.sv
// self-checking bench for the commutation tuning register bank
`timescale 1ns/10ps
`default_nettype none
module test_commutation_tuning_regs;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_edge, comparator_pin;
   logic blanking_active, comparator_filtered, filt_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, f1, f2, rdv, v;
   logic [3:0] pstrb, blank;
   logic [6:0] align;
   logic [1:0] hyst;
   logic [2:0] degl;
   logic errv;
   int n_errors, checks_done, bcnt;
   int pct[8] = '{10, 15, 20, 25, 30, 40, 50, 100};

   ctr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .pwm_edge(pwm_edge), .comparator_pin(comparator_pin), .blanking_active(blanking_active),
      .comparator_filtered(comparator_filtered), .high_inductance_filter_enable(filt_en),
      .align_duty_limit_pct(align), .standby_exit_hysteresis(hyst), .edge_blanking_time(blank),
      .comparator_deglitch_time(degl), .fault_settings_one(f1), .fault_settings_two(f2));

   // clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end

   task automatic end_of_test();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer, result in rdv and errv
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         end_of_test();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, 4'h0);
      chk(rdv, exp);
   endtask : rd

   // one edge pulse, then count blanking cycles
   task automatic pulse();
      @(posedge pclk);
      pwm_edge <= 1'b1;
      @(posedge pclk);
      pwm_edge <= 1'b0;
      bcnt = 0;
      repeat (20) begin
         @(posedge pclk);
         if (blanking_active !== 1'b0) bcnt++;
      end
   endtask : pulse

   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      pwm_edge = 1'b0;
      comparator_pin = 1'b0;
      n_errors = 0;
      checks_done = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h248, 32'h0000_0000);
      rd(12'h250, 32'h0000_0000);
      rd(12'h270, 32'h0020_0000);
      chk(32'(align), 32'h0000_000A);
      chk(32'(filt_en), 32'h0000_0000);
      pulse();
      chk(bcnt, 0);
      for (int i = 0; i < 8; i++) begin
         v = {1'b0, 4'(2 * i + 1), 3'(i), 1'b0, i[0], 1'b1, 3'(i), 2'(i), 16'(i)};
         apb(1'b1, 12'h270, v, 4'hF);
         rd(12'h270, v);
         chk(32'(align), 32'(pct[i]));
         chk(32'(blank), 32'(2 * i + 1));
         chk(32'(degl), 32'(i));
         chk(32'(filt_en), 32'(i[0]));
         chk(32'(hyst), 32'(i % 4));
      end
      apb(1'b1, 12'h270, 32'hFFFF_FFFF, 4'hF);
      apb(1'b1, 12'h270, 32'h0000_0000, 4'h4);
      rd(12'h270, 32'hFF00_FFFF);
      apb(1'b1, 12'h248, 32'hA5A5_0F0F, 4'hF);
      chk(32'(errv), 32'h0000_0000);
      apb(1'b1, 12'h250, 32'h5A5A_F0F0, 4'hF);
      rd(12'h248, 32'hA5A5_0F0F);
      rd(12'h250, 32'h5A5A_F0F0);
      chk(f2, 32'h5A5A_F0F0);
      chk(f1, 32'hA5A5_0F0F);
      apb(1'b1, 12'h24C, 32'hFFFF_FFFF, 4'hF);
      chk(32'(errv), 32'h0000_0001);
      apb(1'b1, 12'h249, 32'hFFFF_FFFF, 4'hF);
      chk(32'(errv), 32'h0000_0001);
      rd(12'h24C, 32'h0000_0000);
      rd(12'h248, 32'hA5A5_0F0F);
      apb(1'b1, 12'h270, 32'h0820_0000, 4'hF);
      pulse();
      chk(bcnt, 10);
      // short glitch must be filtered at deglitch code one
      apb(1'b1, 12'h270, 32'h0120_0000, 4'hF);
      comparator_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      comparator_pin <= 1'b0;
      bcnt = 0;
      repeat (16) begin
         @(posedge pclk);
         if (comparator_filtered !== 1'b0) bcnt++;
      end
      chk(bcnt, 0);
      apb(1'b1, 12'h270, 32'h0020_0000, 4'hF);
      comparator_pin <= 1'b1;
      bcnt = 0;
      repeat (10) begin
         @(posedge pclk);
         if (comparator_filtered === 1'b1) bcnt++;
      end
      chk(bcnt, 7);
      end_of_test();
   end
endmodule : test_commutation_tuning_regs
`default_nettype wire
